//--- core/ras_pkg.sv
/*
  Constants shared by the return-address stack: register indices, field
  positions, reset values and the encodings of the bus handshake.
  Assumes a 32-bit Avalon-MM register bus with byte addresses.
*/
package ras_pkg;

  // Stack geometry
  localparam int          RAS_DEPTH      = 4;
  localparam int          RAS_PC_W       = 10;
  localparam int          RAS_PTR_W      = 2;
  localparam int          RAS_LVL_W      = 3;
  localparam int          RAS_ADDR_W     = 10;
  localparam int          RAS_DATA_W     = 32;

  // Register indices; the byte address is four times the index
  localparam logic [7:0]  RAS_IDX_PTR    = 8'hDF;
  localparam logic [7:0]  RAS_IDX_STATUS = 8'hE0;
  localparam logic [7:0]  RAS_IDX_SLOT0  = 8'hF0;
  localparam logic [7:0]  RAS_IDX_SLOTN  = 8'hF7;

  // Pointer register fields
  localparam int          RAS_IRQEN_BIT  = 7;
  localparam int          RAS_PTR_LSB    = 0;

  // Status register fields
  localparam int          RAS_OVF_BIT    = 0;
  localparam int          RAS_UNF_BIT    = 1;
  localparam int          RAS_LVL_LSB    = 4;

  // Slot high byte keeps program counter bits 9 and 8
  localparam int          RAS_HI_W       = 2;

  // Reset values
  localparam logic [1:0]  RAS_PTR_RST    = 2'h3;
  localparam logic        RAS_IRQEN_RST  = 1'b0;
  localparam logic [7:0]  RAS_SLOT_RST   = 8'h00;
  localparam logic [2:0]  RAS_LVL_RST    = 3'h0;

  // Bus handshake states
  typedef enum logic {
    RAS_BUS_IDLE = 1'b0,
    RAS_BUS_ACK  = 1'b1
  } ras_bus_t;

endpackage

//--- core/ras_return_stack.sv
/*
  Four-level return-address stack with its pointer and the global interrupt
  enable bit, reachable over an Avalon-MM slave with waitrequest.
  Assumes the instruction sequencer pulses push and pop for one mclk cycle
  each and presents the program counter to save together with the push.
*/
`timescale 1ns/100ps

module ras_return_stack
  import ras_pkg::*;
(
  // Clock and reset
  input  wire logic                            mclk,
  input  wire logic                            rstn,
  // Avalon-MM register slave
  input  wire logic [ras_pkg::RAS_ADDR_W-1:0]  address,
  input  wire logic                            read,
  input  wire logic                            write,
  input  wire logic [ras_pkg::RAS_DATA_W-1:0]  writedata,
  input  wire logic [3:0]                      byteenable,
  output logic      [ras_pkg::RAS_DATA_W-1:0]  readdata,
  output logic                                 waitrequest,
  // Instruction sequencer
  input  wire logic                            callPush,
  input  wire logic                            irqPush,
  input  wire logic [ras_pkg::RAS_PC_W-1:0]    pushPc,
  input  wire logic                            subReturn,
  input  wire logic                            irqReturn,
  output logic      [ras_pkg::RAS_PC_W-1:0]    popPc,
  output logic                                 popValid,
  // Status to the core
  output logic                                 globalIrqEnable,
  output logic                                 stackOverflow
);

  import ras_pkg::*;

  // Slot index addressed by a pointer value: 11 -> 0, 10 -> 1, 01 -> 2, 00 -> 3
  function automatic logic [RAS_PTR_W-1:0] slotOf(input logic [RAS_PTR_W-1:0] p);
    slotOf = ~p;
  endfunction

  function automatic logic [7:0] regIndex(input logic [RAS_ADDR_W-1:0] a);
    regIndex = a[9:2];
  endfunction

  logic [RAS_PTR_W-1:0] returnPointer;
  logic [RAS_HI_W-1:0]  returnSlotHigh [RAS_DEPTH];
  logic [7:0]           returnSlotLow  [RAS_DEPTH];
  logic [RAS_LVL_W-1:0] level;
  logic                 stackUnderflow;
  ras_bus_t             busState;

  logic                 doPush;
  logic                 doPop;
  logic [RAS_PTR_W-1:0] pushSlot;
  logic [RAS_PTR_W-1:0] popSlot;
  logic                 busWrite;
  logic [7:0]           wrIndex;
  logic [7:0]           rdIndex;
  logic                 wrPtr;
  logic                 wrStatus;
  logic                 wrSlot;
  logic [RAS_PTR_W-1:0] wrSlotSel;
  logic                 wrSlotHigh;
  logic [RAS_DATA_W-1:0] next_readdata;

  // Both stack-save sources share one push; a push in the same cycle as a
  // pop wins and that pop is dropped, with no popValid
  assign doPush   = callPush | irqPush;
  assign doPop    = (subReturn | irqReturn) & ~doPush;
  assign pushSlot = slotOf(returnPointer);
  assign popSlot  = slotOf(returnPointer + 2'd1);

  // A write takes effect at the edge where waitrequest is seen low
  assign busWrite   = write & ~waitrequest & byteenable[0];
  assign wrIndex    = regIndex(address);
  assign rdIndex    = regIndex(address);
  assign wrPtr      = busWrite & (wrIndex == RAS_IDX_PTR);
  assign wrStatus   = busWrite & (wrIndex == RAS_IDX_STATUS);
  assign wrSlot     = busWrite & (wrIndex >= RAS_IDX_SLOT0) & (wrIndex <= RAS_IDX_SLOTN);
  assign wrSlotSel  = wrIndex[2:1];
  assign wrSlotHigh = wrIndex[0];

  // Bus handshake: exactly one wait cycle, then one cycle with waitrequest low
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      busState    <= RAS_BUS_IDLE;
      waitrequest <= 1'b1;
    end else begin
      case (busState)
        RAS_BUS_IDLE: begin
          if (read | write) begin
            busState    <= RAS_BUS_ACK;
            waitrequest <= 1'b0;
          end
        end
        RAS_BUS_ACK: begin
          busState    <= RAS_BUS_IDLE;
          waitrequest <= 1'b1;
        end
        default: begin
          busState    <= RAS_BUS_IDLE;
          waitrequest <= 1'b1;
        end
      endcase
    end
  end

  // Read mux; unmapped addresses read as zero
  always_comb begin
    next_readdata = '0;
    if (rdIndex == RAS_IDX_PTR) begin
      next_readdata[RAS_IRQEN_BIT] = globalIrqEnable;
      next_readdata[RAS_PTR_LSB +: RAS_PTR_W] = returnPointer;
    end else if (rdIndex == RAS_IDX_STATUS) begin
      next_readdata[RAS_OVF_BIT] = stackOverflow;
      next_readdata[RAS_UNF_BIT] = stackUnderflow;
      next_readdata[RAS_LVL_LSB +: RAS_LVL_W] = level;
    end else if ((rdIndex >= RAS_IDX_SLOT0) && (rdIndex <= RAS_IDX_SLOTN)) begin
      if (rdIndex[0]) begin
        next_readdata[RAS_HI_W-1:0] = returnSlotHigh[rdIndex[2:1]];
      end else begin
        next_readdata[7:0] = returnSlotLow[rdIndex[2:1]];
      end
    end
  end

  // Read data is captured with the acknowledge and stands while it is low
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      readdata <= '0;
    end else if ((busState == RAS_BUS_IDLE) && read) begin
      readdata <= next_readdata;
    end
  end

  // Pointer: hardware push and pop win over a software write in the same cycle
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      returnPointer <= RAS_PTR_RST;
    end else if (doPush) begin
      returnPointer <= returnPointer - 2'd1;
    end else if (doPop) begin
      returnPointer <= returnPointer + 2'd1;
    end else if (wrPtr) begin
      returnPointer <= writedata[RAS_PTR_LSB +: RAS_PTR_W];
    end
  end

  // Global interrupt enable lives in the pointer register
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      globalIrqEnable <= RAS_IRQEN_RST;
    end else if (wrPtr) begin
      globalIrqEnable <= writedata[RAS_IRQEN_BIT];
    end
  end

  // Slot storage; a push is written at the edge that ends the cycle it is requested and wins over a slot write
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < RAS_DEPTH; i++) begin
        returnSlotHigh[i] <= RAS_SLOT_RST[RAS_HI_W-1:0];
        returnSlotLow[i]  <= RAS_SLOT_RST;
      end
    end else if (doPush) begin
      returnSlotHigh[pushSlot] <= pushPc[9:8];
      returnSlotLow[pushSlot]  <= pushPc[7:0];
    end else if (wrSlot) begin
      if (wrSlotHigh) begin
        returnSlotHigh[wrSlotSel] <= writedata[RAS_HI_W-1:0];
      end else begin
        returnSlotLow[wrSlotSel] <= writedata[7:0];
      end
    end
  end

  // Restored address towards the program counter
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      popPc    <= '0;
      popValid <= 1'b0;
    end else begin
      popValid <= doPop;
      if (doPop) begin
        popPc <= {returnSlotHigh[popSlot], returnSlotLow[popSlot]};
      end
    end
  end

  // Fill level follows the pointer; writing the pointer sets the level it
  // implies, so 11 means empty and a full stack cannot be written back
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      level <= RAS_LVL_RST;
    end else if (doPush) begin
      if (level != RAS_LVL_W'(RAS_DEPTH)) begin
        level <= level + 3'd1;
      end
    end else if (doPop) begin
      if (level != 3'd0) begin
        level <= level - 3'd1;
      end
    end else if (wrPtr) begin
      level <= {1'b0, slotOf(writedata[RAS_PTR_LSB +: RAS_PTR_W])};
    end
  end

  // Sticky error flags, write one to clear; a new event wins over the clear
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      stackOverflow <= 1'b0;
    end else if (doPush && (level == RAS_LVL_W'(RAS_DEPTH))) begin
      stackOverflow <= 1'b1;
    end else if (wrStatus && writedata[RAS_OVF_BIT]) begin
      stackOverflow <= 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      stackUnderflow <= 1'b0;
    end else if (doPop && (level == 3'd0)) begin
      stackUnderflow <= 1'b1;
    end else if (wrStatus && writedata[RAS_UNF_BIT]) begin
      stackUnderflow <= 1'b0;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  sequence sPush;
    doPush;
  endsequence

  sequence sPopAlone;
    doPop;
  endsequence

  sequence sPushThenPop;
    sPush ##1 sPopAlone;
  endsequence

  // The checks below pause in reset, so no attempt spans a reset edge
  sequence sHighByteRead;
    read && !waitrequest && rdIndex[7:4] == 4'hF && rdIndex[0];
  endsequence

  sequence sPtrRead;
    read && !waitrequest && rdIndex == RAS_IDX_PTR;
  endsequence

  sequence sOvfKept;
    stackOverflow && !(wrStatus && writedata[RAS_OVF_BIT]);
  endsequence

  // A push at full depth sets the flag again, so it must not count as a clear
  sequence sOvfClear;
    wrStatus && writedata[RAS_OVF_BIT] && !(doPush && level == 3'd4);
  endsequence

  a_push_decrement: assert property (sPush |=>
    returnPointer == $past(returnPointer) - 2'd1)
    else $error("push did not decrement the pointer");

  a_pop_increment: assert property (sPopAlone |=>
    returnPointer == $past(returnPointer) + 2'd1)
    else $error("pop did not increment the pointer");

  a_push_saves_pc: assert property (sPush |=>
    {returnSlotHigh[$past(pushSlot)], returnSlotLow[$past(pushSlot)]} == $past(pushPc))
    else $error("pushed address not stored");

  a_lifo_restore: assert property (sPushThenPop |=>
    popValid && popPc == $past(pushPc, 2))
    else $error("pop did not return the last pushed address");

  a_pop_valid_pulse: assert property (sPopAlone |=>
    popValid ##1 (popValid == $past(doPop)))
    else $error("return value strobe wrong");

  a_no_stray_pop: assert property (!doPop |=> !popValid)
    else $error("return strobe without a pop");

  a_push_wins: assert property ((doPush && (subReturn || irqReturn)) |=> !popValid)
    else $error("pop taken in a push cycle");

  a_fifth_push: assert property ((doPush && level == 3'd4) |=>
    stackOverflow && returnPointer == $past(returnPointer) - 2'd1)
    else $error("overflow not flagged on fifth push");

  a_unf_pop: assert property ((doPop && level == 3'd0) |=>
    stackUnderflow && returnPointer == $past(returnPointer) + 2'd1)
    else $error("pop from empty stack mishandled");

  a_ovf_sticky: assert property (sOvfKept |=> stackOverflow)
    else $error("overflow flag lost without a clear");

  a_ovf_clear: assert property (sOvfClear |=> !stackOverflow)
    else $error("overflow flag not cleared");

  a_level_bound: assert property (level <= 3'd4)
    else $error("fill level beyond four");

  a_ptr_hold: assert property ((!doPush && !doPop && !wrPtr) |=>
    $stable(returnPointer))
    else $error("pointer moved without a request");

  a_ptr_write: assert property ((wrPtr && !doPush && !doPop) |=>
    returnPointer == $past(writedata[RAS_PTR_LSB +: RAS_PTR_W]))
    else $error("pointer field write not applied");

  a_irqen_write: assert property ((wrPtr && !doPush && !doPop) |=>
    globalIrqEnable == $past(writedata[RAS_IRQEN_BIT]) && level == {1'b0, ~returnPointer})
    else $error("pointer register write not applied");

  a_irqen_hold: assert property (!wrPtr |=> $stable(globalIrqEnable))
    else $error("interrupt enable changed without a write");

  a_irqen_read: assert property (sPtrRead |->
    readdata[RAS_IRQEN_BIT] == globalIrqEnable)
    else $error("interrupt enable read back wrong");

  a_slots_hold: assert property ((!doPush && !wrSlot) |=>
    $stable({returnSlotHigh[0], returnSlotHigh[1], returnSlotHigh[2], returnSlotHigh[3],
             returnSlotLow[0], returnSlotLow[1], returnSlotLow[2], returnSlotLow[3]}))
    else $error("stack slot changed without a push or write");

  a_high_byte_zero: assert property (sHighByteRead |->
    readdata[RAS_DATA_W-1:RAS_HI_W] == '0)
    else $error("slot high byte has bits above 9:8");

  a_wait_once: assert property (((read || write) && waitrequest) |=> !waitrequest ##1 waitrequest)
    else $error("waitrequest handshake broken");

endmodule

//--- sim/ras_return_stack_bench.sv
/*
  Self-checking bench of the return stack: Avalon-MM tasks and push/pop steps.
  Assumes the sequencer model beside it and a one-cycle bus answer.
*/
`timescale 1ns/100ps

module ras_return_stack_bench;
  import ras_pkg::*;
  logic                  mclk;
  logic                  rstn;
  logic [RAS_ADDR_W-1:0] address;
  logic                  read;
  logic                  write;
  logic [RAS_DATA_W-1:0] writedata;
  logic [3:0]            byteenable;
  logic [RAS_DATA_W-1:0] readdata;
  logic                  waitrequest;
  logic                  callPush;
  logic                  irqPush;
  logic [RAS_PC_W-1:0]   pushPc;
  logic                  subReturn;
  logic                  irqReturn;
  logic [RAS_PC_W-1:0]   popPc;
  logic                  popValid;
  logic                  globalIrqEnable;
  logic                  stackOverflow;
  int                    fail_count = 0;
  int                    checks = 0;
  logic [RAS_PC_W-1:0]   popSeen[$];
  logic [RAS_PC_W-1:0]   pcTab[4] = '{10'h3A5, 10'h15A, 10'h2C3, 10'h03C};

  ras_return_stack i_ras_return_stack (.mclk(mclk), .rstn(rstn), .address(address),
    .read(read), .write(write), .writedata(writedata), .byteenable(byteenable),
    .readdata(readdata), .waitrequest(waitrequest), .callPush(callPush),
    .irqPush(irqPush), .pushPc(pushPc), .subReturn(subReturn), .irqReturn(irqReturn),
    .popPc(popPc), .popValid(popValid), .globalIrqEnable(globalIrqEnable),
    .stackOverflow(stackOverflow));
  ras_seq_model i_ras_seq_model (.mclk(mclk), .callPush(callPush), .irqPush(irqPush),
    .pushPc(pushPc), .subReturn(subReturn), .irqReturn(irqReturn));

  initial mclk = 1'b0;
  always #5 mclk = ~mclk;

  // Restored addresses in the order they come back
  always @(posedge mclk) begin
    if (popValid === 1'b1) begin
      popSeen.push_back(popPc);
    end
  end

  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic cmp_reg(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic cmp_bit(input string nm, input logic e, input logic g);
    cmp_reg(nm, {31'h0, e}, {31'h0, g});
  endtask

  task automatic cmp_pc(input logic [9:0] e, input logic [9:0] g);
    cmp_reg("popPc", {22'h0, e}, {22'h0, g});
  endtask

  task automatic bus_xfer(input logic isWr, input logic [7:0] idx, input logic [31:0] wd,
                          input logic [3:0] be, output logic [31:0] rd);
    int n;
    @(posedge mclk);
    address    <= {idx, 2'b00};
    read       <= !isWr;
    write      <= isWr;
    writedata  <= wd;
    byteenable <= be;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (waitrequest !== 1'b0 && n < 20);
    rd = readdata;
    read  <= 1'b0;
    write <= 1'b0;
    if (waitrequest !== 1'b0) begin
      cmp_bit("waitrequest", 1'b0, waitrequest);
      end_sim();
    end
  endtask

  task automatic rd_chk(input logic [7:0] idx, input logic [31:0] e);
    logic [31:0] rd;
    bus_xfer(1'b0, idx, 32'h0, 4'hF, rd);
    cmp_reg($sformatf("register %h", idx), e, rd);
  endtask

  task automatic wr_reg(input logic [7:0] idx, input logic [31:0] d, input logic [3:0] be);
    logic [31:0] rd;
    bus_xfer(1'b1, idx, d, be, rd);
  endtask

  task automatic seq(input logic [2:0] k, input logic [9:0] pc);
    i_ras_seq_model.step(k, pc);
  endtask

  initial begin
    rstn = 1'b0;
    address = '0;
    read = 1'b0;
    write = 1'b0;
    writedata = '0;
    byteenable = 4'hF;
    repeat (2) @(posedge mclk);
    rstn <= 1'b1;
    cmp_bit("globalIrqEnable", 1'b0, globalIrqEnable);
    cmp_bit("stackOverflow", 1'b0, stackOverflow);
    rd_chk(RAS_IDX_PTR, 32'h03);
    for (int i = 0; i < 8; i++) rd_chk(RAS_IDX_SLOT0 + 8'(i), 32'h0);
    $display("test reset values done");
    wr_reg(RAS_IDX_PTR, 32'h83, 4'hF);
    rd_chk(RAS_IDX_PTR, 32'h83);
    cmp_bit("globalIrqEnable", 1'b1, globalIrqEnable);
    // Calls and irq entries alternate; the enable bit must ride along untouched
    for (int i = 0; i < 4; i++) begin
      seq((i % 2) ? 3'h2 : 3'h1, pcTab[i]);
      seq(3'h0, 10'h0);
      rd_chk(RAS_IDX_PTR, 32'h80 | {30'h0, 2'(2 - i)});
    end
    for (int i = 0; i < 4; i++) begin
      rd_chk(RAS_IDX_SLOT0 + 8'(2 * i), {24'h0, pcTab[i][7:0]});
      rd_chk(RAS_IDX_SLOT0 + 8'(2 * i + 1), {30'h0, pcTab[i][9:8]});
    end
    cmp_bit("stackOverflow", 1'b0, stackOverflow);
    $display("test four pushes done");
    for (int i = 0; i < 4; i++) seq((i % 2) ? 3'h4 : 3'h3, 10'h0);
    repeat (3) seq(3'h0, 10'h0);
    cmp_reg("pop count", 32'd4, 32'(popSeen.size()));
    for (int i = 0; i < 4; i++) cmp_pc(pcTab[3 - i], popSeen[i]);
    popSeen.delete();
    rd_chk(RAS_IDX_PTR, 32'h83);
    $display("test back to back pops done");
    seq(3'h5, 10'h2AA);
    seq(3'h0, 10'h0);
    rd_chk(RAS_IDX_PTR, 32'h82);
    seq(3'h3, 10'h0);
    repeat (3) seq(3'h0, 10'h0);
    cmp_reg("pop count", 32'd1, 32'(popSeen.size()));
    cmp_pc(10'h2AA, popSeen[0]);
    seq(3'h1, 10'h155);
    seq(3'h3, 10'h0);
    repeat (3) seq(3'h0, 10'h0);
    cmp_reg("pop count", 32'd2, 32'(popSeen.size()));
    cmp_pc(10'h155, popSeen[1]);
    $display("test push with pop done");
    for (int i = 0; i < 5; i++) seq(3'h1, 10'(i));
    seq(3'h0, 10'h0);
    rd_chk(RAS_IDX_PTR, 32'h82);
    rd_chk(RAS_IDX_SLOT0, 32'h04);
    cmp_bit("stackOverflow", 1'b1, stackOverflow);
    rd_chk(RAS_IDX_STATUS, 32'h41);
    wr_reg(RAS_IDX_STATUS, 32'h01, 4'hF);
    rd_chk(RAS_IDX_STATUS, 32'h40);
    cmp_bit("stackOverflow", 1'b0, stackOverflow);
    $display("test overflow done");
    wr_reg(RAS_IDX_PTR, 32'h03, 4'hE);
    rd_chk(RAS_IDX_PTR, 32'h82);
    wr_reg(RAS_IDX_PTR, 32'h03, 4'hF);
    rd_chk(RAS_IDX_PTR, 32'h03);
    cmp_bit("globalIrqEnable", 1'b0, globalIrqEnable);
    rd_chk(8'h10, 32'h0);
    $display("test register access done");
    // A pop from an empty stack still wraps the pointer and flags underflow
    seq(3'h3, 10'h0);
    seq(3'h0, 10'h0);
    rd_chk(RAS_IDX_PTR, 32'h00);
    rd_chk(RAS_IDX_STATUS, 32'h02);
    wr_reg(RAS_IDX_STATUS, 32'h02, 4'hF);
    rd_chk(RAS_IDX_STATUS, 32'h00);
    $display("test empty pop done");
    wr_reg(RAS_IDX_PTR, 32'h81, 4'hF);
    @(posedge mclk);
    rstn <= 1'b0;
    repeat (2) @(posedge mclk);
    rstn <= 1'b1;
    cmp_bit("globalIrqEnable", 1'b0, globalIrqEnable);
    rd_chk(RAS_IDX_PTR, 32'h03);
    rd_chk(RAS_IDX_SLOT0, 32'h0);
    rd_chk(RAS_IDX_SLOT0 + 8'h6, 32'h0);
    $display("test second reset done");
    end_sim();
  end
endmodule

//--- sim/ras_seq_model.sv
/*
  Sequencer stand-in: drives the push and pop strobes of the return stack.
  Assumes the bench calls step once per cycle, so no strobe is set twice.
*/
`timescale 1ns/100ps

module ras_seq_model
  import ras_pkg::*;
(
  // Clock
  input  wire logic                          mclk,
  // Stack requests
  output logic                               callPush,
  output logic                               irqPush,
  output logic [ras_pkg::RAS_PC_W-1:0]       pushPc,
  output logic                               subReturn,
  output logic                               irqReturn
);
  initial begin
    callPush  = 1'b0;
    irqPush   = 1'b0;
    pushPc    = '0;
    subReturn = 1'b0;
    irqReturn = 1'b0;
  end

  // Kind 0 idle, 1 call, 2 irq entry, 3 return, 4 irq return, 5 call and return
  task automatic step(input logic [2:0] kind, input logic [RAS_PC_W-1:0] pc);
    @(posedge mclk);
    callPush  <= (kind == 3'h1) || (kind == 3'h5);
    irqPush   <= kind == 3'h2;
    // Off a push the address toggles, so a stale value never looks fresh
    pushPc    <= (kind inside {3'h1, 3'h2, 3'h5}) ? pc : ~pushPc;
    subReturn <= (kind == 3'h3) || (kind == 3'h5);
    irqReturn <= kind == 3'h4;
  endtask
endmodule
